// >>> shared/tmg_pkg.sv
`default_nettype none
package tmg_pkg;
	// register word indices, byte address is four times the index
	localparam logic [9:0] IDX_MASK_1L = 10'h00a;
	localparam logic [9:0] IDX_MASK_1U = 10'h00b;
	localparam logic [9:0] IDX_MASK_2L = 10'h00c;
	localparam logic [9:0] IDX_MASK_2U = 10'h00d;
	localparam logic [9:0] IDX_CTRL    = 10'h00e;
	localparam logic [9:0] IDX_PATHCFG = 10'h020;
	localparam logic [9:0] IDX_STATUS  = 10'h021;

	// reset values
	localparam logic [7:0] RST_MASK    = 8'hff;
	localparam logic [7:0] RST_CTRL    = 8'h00;
	localparam logic [8:0] RST_PATHCFG = 9'h000;

	// control register fields
	localparam int CTRL_POL_BIT = 7;
	localparam int CTRL_OFF_LSB = 4;
	localparam int CTRL_DLY_LSB = 0;

	// path config register fields
	localparam int CFG_FLT_LSB  = 0;
	localparam int CFG_SRC_LSB  = 2;
	localparam int CFG_GAIN_BIT = 5;
	localparam int CFG_RATE_LSB = 6;

	// status register fields
	localparam int STS_DLY_LSB = 24;

	// fifth path filter codes and source code
	localparam logic [1:0] FLT_TRACKING = 2'h2;
	localparam logic [2:0] SRC_MASKED   = 3'h4;

	// sample width, full scale and offset step of three percent
	localparam int DW = 24;
	localparam logic [DW-1:0] FULL_SCALE = 24'h7fffff;
	localparam int OFFSET_PCT = 3;
	localparam logic [DW-1:0] OFFSET_STEP =
		DW'((32'(FULL_SCALE) * OFFSET_PCT) / 100);

	// delay line depth
	localparam int DLY_AW = 6;

	typedef struct packed {
		logic          valid;
		logic          second_input;
		logic [3:0]    slot;
		logic [DW-1:0] data;
	} tmg_slot_t;

	typedef struct packed {
		logic               valid;
		logic [3:0][DW-1:0] ch;
	} tmg_main_t;

	// whole samples of added delay per code, rates 32 .. 96 kHz
	function automatic logic [5:0] tmg_delay_samples(
		input logic [3:0] code,
		input logic [2:0] rate
	);
		logic [15:0][5:0] t;
		t = '0;
		unique case (rate)
			3'h0: t = {6'd16, 6'd15, 6'd15, 6'd14, 6'd13, 6'd12, 6'd11,
				6'd10, 6'd10, 6'd9, 6'd8, 6'd7, 6'd6, 6'd5, 6'd3, 6'd0};
			3'h1: t = {6'd22, 6'd21, 6'd20, 6'd18, 6'd17, 6'd16, 6'd15,
				6'd14, 6'd13, 6'd12, 6'd11, 6'd10, 6'd9, 6'd7, 6'd4, 6'd0};
			3'h2: t = {6'd24, 6'd23, 6'd21, 6'd20, 6'd19, 6'd18, 6'd17,
				6'd15, 6'd14, 6'd13, 6'd12, 6'd11, 6'd10, 6'd7, 6'd5, 6'd0};
			3'h3: t = {6'd32, 6'd30, 6'd29, 6'd27, 6'd26, 6'd24, 6'd22,
				6'd21, 6'd19, 6'd18, 6'd16, 6'd14, 6'd13, 6'd10, 6'd6, 6'd0};
			3'h4: t = {6'd44, 6'd42, 6'd40, 6'd38, 6'd36, 6'd33, 6'd31,
				6'd29, 6'd27, 6'd24, 6'd22, 6'd20, 6'd18, 6'd13, 6'd9, 6'd0};
			3'h5: t = {6'd48, 6'd46, 6'd43, 6'd41, 6'd38, 6'd36, 6'd34,
				6'd31, 6'd29, 6'd26, 6'd24, 6'd22, 6'd19, 6'd14, 6'd10, 6'd0};
			default: t = '0;
		endcase
		return t[code];
	endfunction : tmg_delay_samples
endpackage : tmg_pkg
`default_nettype wire

// >>> hdl/tmg_slot_gate.sv
`timescale 1ns/1ps
`default_nettype none
module tmg_slot_gate (
	input  wire logic [3:0][7:0] mask,
	input  wire logic [2:0]      src,
	output logic      [31:0]     incl
);
	// one gate per slot, index = input * 16 + slot
	for (genvar s = 0; s < 32; s++) begin : g_slot
		localparam int REG = s / 8;
		localparam int BIT = 7 - (s % 8);
		localparam int N   = s % 16;
		always_comb begin
			if (src == tmg_pkg::SRC_MASKED) begin
				incl[s] = ~mask[REG][BIT];
			end else if (src[2] == 1'b0 && s < 16) begin
				// fixed group of three slots on first input
				incl[s] = (N >= 4 * int'(src)) && (N <= 4 * int'(src) + 2);
			end else begin
				incl[s] = 1'b0;
			end
		end
	end
endmodule : tmg_slot_gate
`default_nettype wire

// >>> hdl/tmg_group_delay.sv
`timescale 1ns/1ps
`default_nettype none
module tmg_group_delay (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               ce,
	input  wire logic [5:0]         dly,
	input  wire tmg_pkg::tmg_main_t in_smp,
	output tmg_pkg::tmg_main_t      out_smp
);
	typedef struct packed {
		logic [tmg_pkg::DLY_AW-1:0] wr;
		tmg_pkg::tmg_main_t         out;
	} tmg_gd_state_t;

	tmg_gd_state_t                     s_q;
	tmg_gd_state_t                     s_d;
	logic [3:0][tmg_pkg::DW-1:0]       mem [2**tmg_pkg::DLY_AW];
	logic [tmg_pkg::DLY_AW-1:0]        rd;

	assign rd = s_q.wr - dly;
	assign out_smp = s_q.out;

	always_comb begin
		s_d = s_q;
		s_d.out.valid = 1'b0;
		if (in_smp.valid) begin
			s_d.wr = s_q.wr + (tmg_pkg::DLY_AW)'(1);
			s_d.out.valid = 1'b1;
			s_d.out.ch = (dly == 6'h00) ? in_smp.ch : mem[rd];
		end
	end

	// sample ring store
	always_ff @(posedge pclk) begin
		if (ce && in_smp.valid) begin
			mem[s_q.wr] <= in_smp.ch;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end
endmodule : tmg_group_delay
`default_nettype wire

// >>> hdl/tmg_track_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - four 8-bit masks pick slots kept from max detect and tracking.
// - a zero mask bit includes its slot; all ones exclude all eight.
// - first input upper mask bit 7 is slot 9 down to bit 0 slot 16.
// - second input lower mask bit 7 is slot 1 down to bit 0 slot 8.
// - second input upper mask bit 7 is slot 9 down to bit 0 slot 16.
// - in tracking mode the polarity bit moves reference to full scale.
// - outside tracking mode the polarity bit inverts the reference.
// - a 3-bit offset adds three percent of full scale per step.
// - polarity and gain both set double the offset.
// - a 4-bit delay field delays only the four main channels.
// - delay is whole samples per rate, 16/24/48 at 32/48/96 kHz top.
// - tracking mode only when the filter field is code 10.
// - masks steer the fifth path only with source code 100.
module tmg_track_ctrl (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                ce,
	input  wire logic [11:0]         paddr,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire tmg_pkg::tmg_slot_t  slot_in,
	input  wire logic                frame_end,
	input  wire tmg_pkg::tmg_main_t  main_in,
	output tmg_pkg::tmg_main_t       main_out,
	output logic                     track_valid,
	output logic      [23:0]         track_data
);
	typedef struct packed {
		logic [3:0][7:0] mask;
		logic [7:0]      ctrl;
		logic [8:0]      pathcfg;
		logic [23:0]     env;
		logic [23:0]     track;
		logic            tvalid;
		logic [31:0]     rdata;
		logic            ready;
		logic            slverr;
	} tmg_state_t;

	tmg_state_t         s_q;
	tmg_state_t         s_d;
	logic [31:0]        incl;
	logic [9:0]         idx;
	logic               setup;
	logic               access;
	logic               mapped;
	logic               pol;
	logic [2:0]         offs_code;
	logic [3:0]         dly_code;
	logic [1:0]         flt;
	logic [2:0]         src;
	logic               gain;
	logic [2:0]         rate;
	logic [5:0]         dly_smp;
	logic [23:0]        mag;
	logic [23:0]        newmax;
	logic               hit;
	logic signed [26:0] offs;
	logic signed [26:0] base;
	logic signed [26:0] sum;
	logic [23:0]        outval;
	logic [23:0]        env_nx;
	logic [6:0]         reg_hit;
	logic [31:0]        rd_word;
	logic [3:0]         wr_mask;
	logic               wr_ctrl;
	logic               wr_cfg;
	logic               track_mode;
	logic               sat_hi;
	logic               sat_lo;

	// field views
	assign pol       = s_q.ctrl[tmg_pkg::CTRL_POL_BIT];
	assign offs_code = s_q.ctrl[tmg_pkg::CTRL_OFF_LSB +: 3];
	assign dly_code  = s_q.ctrl[tmg_pkg::CTRL_DLY_LSB +: 4];
	assign flt       = s_q.pathcfg[tmg_pkg::CFG_FLT_LSB +: 2];
	assign src       = s_q.pathcfg[tmg_pkg::CFG_SRC_LSB +: 3];
	assign gain      = s_q.pathcfg[tmg_pkg::CFG_GAIN_BIT];
	assign rate      = s_q.pathcfg[tmg_pkg::CFG_RATE_LSB +: 3];

	assign dly_smp = tmg_pkg::tmg_delay_samples(dly_code, rate);

	tmg_slot_gate u_gate (
		.mask (s_q.mask),
		.src  (src),
		.incl (incl)
	);

	tmg_group_delay u_delay (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.dly     (dly_smp),
		.in_smp  (main_in),
		.out_smp (main_out)
	);

	// bus phase decode
	assign idx    = paddr[11:2];
	assign setup  = psel && !penable;
	assign access = psel && penable && s_q.ready;

	// one-hot decode of the word index
	always_comb begin
		reg_hit = '0;
		unique case (idx)
			tmg_pkg::IDX_MASK_1L: reg_hit[0] = 1'b1;
			tmg_pkg::IDX_MASK_1U: reg_hit[1] = 1'b1;
			tmg_pkg::IDX_MASK_2L: reg_hit[2] = 1'b1;
			tmg_pkg::IDX_MASK_2U: reg_hit[3] = 1'b1;
			tmg_pkg::IDX_CTRL:    reg_hit[4] = 1'b1;
			tmg_pkg::IDX_PATHCFG: reg_hit[5] = 1'b1;
			tmg_pkg::IDX_STATUS:  reg_hit[6] = 1'b1;
			default:              reg_hit = '0;
		endcase
	end

	// unmapped words answer with an error
	assign mapped = |reg_hit;

	// write strobes on the access edge only, status is read only
	assign wr_mask = (access && pwrite) ? reg_hit[3:0] : 4'h0;
	assign wr_ctrl = access && pwrite && reg_hit[4];
	assign wr_cfg  = access && pwrite && reg_hit[5];

	// read mux, unused upper bits read as zero
	always_comb begin
		rd_word = '0;
		for (int m = 0; m < 4; m++) begin
			if (reg_hit[m]) begin
				rd_word[7:0] = s_q.mask[m];
			end
		end
		if (reg_hit[4]) begin
			rd_word[7:0] = s_q.ctrl;
		end
		if (reg_hit[5]) begin
			rd_word[8:0] = s_q.pathcfg;
		end
		// status word: tracked value and delay in use
		if (reg_hit[6]) begin
			rd_word[23:0] = s_q.track;
			rd_word[tmg_pkg::STS_DLY_LSB +: 6] = dly_smp;
		end
	end

	// magnitude of incoming slot sample, clamped at full scale
	always_comb begin
		if (!slot_in.data[23]) begin
			mag = slot_in.data;
		end else if (slot_in.data == 24'h800000) begin
			mag = tmg_pkg::FULL_SCALE;
		end else begin
			mag = 24'((~slot_in.data) + 24'h000001);
		end
	end

	assign hit = slot_in.valid && incl[{slot_in.second_input, slot_in.slot}];
	assign newmax = (hit && mag > s_q.env) ? mag : s_q.env;

	// offset, doubled with polarity and gain
	always_comb begin
		offs = 27'(offs_code) * 27'(tmg_pkg::OFFSET_STEP);
		if (pol && gain) begin
			offs = offs <<< 1;
		end
	end

	assign track_mode = (flt == tmg_pkg::FLT_TRACKING);

	// tracking reference from frame maximum
	always_comb begin
		if (track_mode) begin
			base = pol ? 27'(tmg_pkg::FULL_SCALE) - 27'(newmax)
				: 27'(newmax);
		end else begin
			base = pol ? -27'(newmax) : 27'(newmax);
		end
	end

	// signed sum, saturated at both ends to the 24-bit signed range
	always_comb begin
		sum = base + offs;
		sat_hi = sum > $signed(27'(tmg_pkg::FULL_SCALE));
		sat_lo = sum < -$signed(27'(tmg_pkg::FULL_SCALE)) - 27'sd1;
		if (sat_hi) begin
			outval = tmg_pkg::FULL_SCALE;
		end else if (sat_lo) begin
			outval = 24'h800000;
		end else begin
			outval = sum[23:0];
		end
	end

	// running frame maximum, restarted after each frame end
	always_comb begin
		if (frame_end) begin
			env_nx = '0;
		end else begin
			env_nx = newmax;
		end
	end

	// next state
	always_comb begin
		s_d = s_q;
		s_d.tvalid = 1'b0;
		s_d.ready = 1'b0;
		s_d.slverr = 1'b0;
		// frame close latches the tracked sample
		if (frame_end) begin
			s_d.track = outval;
			s_d.tvalid = 1'b1;
		end
		s_d.env = env_nx;
		// answer prepared in setup, shown in access
		if (setup) begin
			s_d.ready = 1'b1;
			s_d.slverr = !mapped;
			s_d.rdata = rd_word;
		end
		// register writes at the access edge
		for (int m = 0; m < 4; m++) begin
			if (wr_mask[m]) begin
				s_d.mask[m] = pwdata[7:0];
			end
		end
		if (wr_ctrl) begin
			s_d.ctrl = pwdata[7:0];
		end
		if (wr_cfg) begin
			s_d.pathcfg = pwdata[8:0];
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.mask <= {4{tmg_pkg::RST_MASK}};
			s_q.ctrl <= tmg_pkg::RST_CTRL;
			s_q.pathcfg <= tmg_pkg::RST_PATHCFG;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// outputs straight from state
	assign prdata      = s_q.rdata;
	assign pready      = s_q.ready;
	assign pslverr     = s_q.slverr;
	assign track_valid = s_q.tvalid;
	assign track_data  = s_q.track;
endmodule : tmg_track_ctrl
`default_nettype wire

// >>> sim/tmg_track_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
module tmg_track_ctrl_checker (
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               ce,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic [31:0]        prdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire logic               frame_end,
	input wire tmg_pkg::tmg_main_t main_in,
	input wire tmg_pkg::tmg_main_t main_out,
	input wire logic               track_valid,
	input wire logic [23:0]        track_data
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// apb setup cycle taken
	sequence s_setup;
		psel && !penable && ce;
	endsequence
	// apb handshake
	a_setup_answer: assert property (s_setup |=> pready)
		else $error("no pready after setup");
	a_ready_single: assert property (pready && ce |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (pready && $past(ce) |-> $past(psel && !penable))
		else $error("pready without setup");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_zero: assert property (pslverr |-> prdata == 32'h0)
		else $error("read data on refused access");
	// tracking pulse and hold
	a_track_pulse: assert property (frame_end && ce |=> track_valid)
		else $error("no tracking pulse after frame end");
	a_track_cause: assert property (track_valid && $past(ce) |-> $past(frame_end))
		else $error("tracking pulse without frame end");
	a_track_hold: assert property (!track_valid |-> $stable(track_data))
		else $error("tracking value moved outside pulse");
	// main channel pulse
	a_main_pulse: assert property (main_in.valid && ce |=> main_out.valid)
		else $error("no main output after main input");
	a_main_cause: assert property (main_out.valid && $past(ce) |-> $past(main_in.valid))
		else $error("main output without input");
endmodule : tmg_track_ctrl_checker
bind tmg_track_ctrl tmg_track_ctrl_checker tmg_track_ctrl_checker_i (.pclk,
	.presetn, .ce, .psel, .penable, .prdata, .pready, .pslverr, .frame_end,
	.main_in, .main_out, .track_valid, .track_data);
`default_nettype wire

// >>> sim/tmg_track_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module tmg_track_ctrl_bench;
	logic               pclk, presetn, ce, psel, penable, pwrite;
	logic               frame_end, pready, pslverr, track_valid, er;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, rd;
	logic [23:0]        track_data;
	tmg_pkg::tmg_slot_t slot_in;
	tmg_pkg::tmg_main_t main_in, main_out;
	int                 mismatches, comparisons, cycles;

	tmg_track_ctrl tmg_track_ctrl_i (.pclk, .presetn, .ce, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .slot_in,
		.frame_end, .main_in, .main_out, .track_valid, .track_data);

	// clock and hang guard
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			summarize();
		end
	end

	task summarize;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : summarize

	task check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	// one apb transfer, held until pready
	task apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	// one included slot, then its excluded neighbour in the same cycle as frame end
	task frame(input logic sec, input logic [3:0] s, input logic [23:0] d,
		input logic [23:0] exp);
		@(posedge pclk);
		slot_in <= {1'h1, sec, s, d};
		@(posedge pclk);
		slot_in <= {1'h1, sec, s + 4'h1, 24'h700000};
		frame_end <= 1'h1;
		@(posedge pclk);
		slot_in <= '0;
		frame_end <= 1'h0;
		@(posedge pclk);
		check(track_valid, 32'h1);
		check(track_data, exp);
	endtask : frame

	task t_regs;
		apb(1'h0, tmg_pkg::IDX_MASK_2U, 32'h0);
		check(rd, 32'hff);
		apb(1'h0, tmg_pkg::IDX_CTRL, 32'h0);
		check(rd, 32'h0);
		apb(1'h1, tmg_pkg::IDX_MASK_1U, 32'h5a);
		apb(1'h0, tmg_pkg::IDX_MASK_1U, 32'h0);
		check(rd, 32'h5a);
		apb(1'h0, 10'h3ff, 32'h0);
		check({er, rd[30:0]}, 32'h80000000);
	endtask : t_regs

	// clock enable low: a frame end leaves no pulse
	task t_freeze;
		@(posedge pclk);
		ce <= 1'h0;
		frame_end <= 1'h1;
		@(posedge pclk);
		frame_end <= 1'h0;
		@(posedge pclk);
		check(track_valid, 32'h0);
		ce <= 1'h1;
	endtask : t_freeze

	task t_mask(input logic [9:0] idx, input logic sec, input logic [3:0] s);
		apb(1'h1, idx, 32'h7f);
		frame(sec, s, 24'h000123, 24'h000123);
		apb(1'h1, idx, 32'hff);
		frame(sec, s, 24'h000123, 24'h0);
	endtask : t_mask

	task t_out;
		apb(1'h1, tmg_pkg::IDX_MASK_2L, 32'h7f);
		apb(1'h1, tmg_pkg::IDX_CTRL, 32'h90);
		frame(1'h1, 4'h0, 24'h100, tmg_pkg::OFFSET_STEP - 24'h100);
		apb(1'h1, tmg_pkg::IDX_CTRL, 32'h80);
		frame(1'h1, 4'h0, 24'h100, 24'hffff00);
		apb(1'h1, tmg_pkg::IDX_CTRL, 32'h30);
		frame(1'h1, 4'h0, 24'h100, 24'(tmg_pkg::OFFSET_STEP * 3 + 256));
		apb(1'h1, tmg_pkg::IDX_PATHCFG, 32'h12);
		apb(1'h1, tmg_pkg::IDX_CTRL, 32'h80);
		frame(1'h1, 4'h0, 24'h100, 24'h7ffeff);
		apb(1'h1, tmg_pkg::IDX_PATHCFG, 32'h32);
		apb(1'h1, tmg_pkg::IDX_CTRL, 32'hf0);
		frame(1'h1, 4'h0, 24'h7fffff, 24'(tmg_pkg::OFFSET_STEP * 14));
		apb(1'h1, tmg_pkg::IDX_PATHCFG, 32'h14);
		frame(1'h1, 4'h0, 24'h100, 24'(tmg_pkg::OFFSET_STEP * 7));
	endtask : t_out

	task t_delay(input logic [3:0] code, input logic [2:0] rate, int n);
		// delay changed with main input idle
		apb(1'h1, tmg_pkg::IDX_CTRL, {28'h0, code});
		apb(1'h1, tmg_pkg::IDX_PATHCFG, {23'h0, rate, 6'h0});
		apb(1'h0, tmg_pkg::IDX_STATUS, 32'h0);
		check(rd[29:24], n);
		for (int k = 0; k < 60; k++) begin
			@(posedge pclk);
			main_in <= {1'h1, 72'h0, 24'(k)};
			if (k >= n + 2) check(main_out.ch[0], k - 2 - n);
		end
		@(posedge pclk);
		main_in <= '0;
	endtask : t_delay

	// reset, then scenarios in turn
	initial begin
		{pclk, presetn, psel, penable, pwrite, frame_end} = '0;
		{paddr, pwdata, slot_in, main_in} = '0;
		ce = 1'h1;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_freeze();
		apb(1'h1, tmg_pkg::IDX_PATHCFG, 32'h10);
		t_mask(tmg_pkg::IDX_MASK_1U, 1'h0, 4'h8);
		t_mask(tmg_pkg::IDX_MASK_2L, 1'h1, 4'h0);
		t_mask(tmg_pkg::IDX_MASK_2U, 1'h1, 4'h8);
		t_out();
		t_delay(4'hf, 3'h0, 16);
		t_delay(4'hf, 3'h2, 24);
		t_delay(4'hf, 3'h5, 48);
		t_delay(4'h1, 3'h0, 3);
		t_delay(4'h0, 3'h5, 0);
		summarize();
	end
endmodule : tmg_track_ctrl_bench
`default_nettype wire
